// ===== rtl/srfp_core.sv
// Receive core end: wide FIFO read port, status RAM, delay line, status clock
`timescale 1ns/1ns
module srfp_core
  import srfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link to fabric
  srfp_if.core lnk,
  // Receive data clock, one-cycle enable per data clock edge
  input wire logic rx_data_clk,
  // Received words entering the FIFO
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [srfp_pkg::DATA_W-1:0] in_data,
  input wire logic [srfp_pkg::BE_W-1:0] in_be,
  input wire logic [srfp_pkg::PORT_W-1:0] in_port,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic in_err,
  // Status interface and delayed clock path
  output logic [srfp_pkg::STAT_W-1:0] fifo_status,
  output logic [srfp_pkg::PORT_W-1:0] fifo_status_port,
  output logic rx_clk_path
);
  import srfp_pkg::*;
  localparam int WORD_W = DATA_W + BE_W + PORT_W + 3;

  logic [WORD_W-1:0] store [DEPTH];
  logic [BUF_W-1:0] wr_ptr;
  logic [BUF_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [WORD_W-1:0] head;
  logic head_match;
  logic do_push;
  logic do_pop;
  logic next_empty;
  logic [DIV_W-1:0] div_cnt;
  logic status_tick;
  logic [PORT_W-1:0] cal_port;
  logic [STAT_W-1:0] ram_status;
  logic [STAT_W-1:0] own_status;
  logic [TAP_MAX:0] dly_line;
  logic [TAP_W-1:0] tap_eff;

  // ==========================================
  // FIFO storage
  assign head = store[rd_ptr];
  // Read address picks which buffer may be drained
  assign head_match = head[PORT_W+2:3] == {{(PORT_W-BUF_W){1'b0}}, lnk.wide_fifo_rd_addr} ||
                      head[BUF_W+2:3] == lnk.wide_fifo_rd_addr;
  assign do_push = in_valid && in_ready;
  assign do_pop = lnk.wide_fifo_rd_clk && lnk.wide_fifo_rd && count != '0 && head_match;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      in_ready <= 1'b0;
    else
      in_ready <= (count + CNT_W'(do_push)) < FIFO_FULL - CNT_W'(do_pop) + CNT_W'(do_pop);
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_store
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        store[i] <= '0;
      else if (do_push && wr_ptr == BUF_W'(i))
        store[i] <= {in_data, in_be, in_port, in_sop, in_eop, in_err};
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + PTR_ONE;
      if (do_pop)
        rd_ptr <= rd_ptr + PTR_ONE;
      if (do_push && !do_pop)
        count <= count + CNT_ONE;
      else if (do_pop && !do_push)
        count <= count - CNT_ONE;
    end
  end

  // ==========================================
  // Read port
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lnk.wide_fifo_rd_valid <= 1'b0;
      lnk.wide_fifo_rd_data <= '0;
      lnk.wide_fifo_byte_en <= '0;
      lnk.wide_fifo_port_ident <= '0;
      lnk.wide_fifo_pkt_start <= 1'b0;
      lnk.wide_fifo_pkt_end <= 1'b0;
      lnk.wide_fifo_word_error <= 1'b0;
    end
    else
    begin
      lnk.wide_fifo_rd_valid <= do_pop;
      if (do_pop)
      begin
        lnk.wide_fifo_rd_data <= head[WORD_W-1 -: DATA_W];
        lnk.wide_fifo_byte_en <= head[WORD_W-DATA_W-1 -: BE_W];
        lnk.wide_fifo_port_ident <= head[PORT_W+2:3];
        lnk.wide_fifo_pkt_start <= head[2];
        lnk.wide_fifo_pkt_end <= head[1];
        lnk.wide_fifo_word_error <= head[0];
      end
    end
  end

  // ==========================================
  // Empty flag, seen after this cycle's push and pop
  always_comb
  begin
    logic [CNT_W-1:0] after;
    after = count + CNT_W'(do_push) - CNT_W'(do_pop);
    if (lnk.empty_flag_type_select)
      next_empty = after <= QUARTER - CNT_ONE;
    else
      next_empty = after == '0;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      lnk.wide_fifo_empty_flag <= 1'b1;
    else
      lnk.wide_fifo_empty_flag <= next_empty;
  end

  // ==========================================
  // Status RAM, written from the fabric
  // enable gated write
  srfp_status_ram u_ram (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(lnk.status_ram_wr_clk && lnk.status_ram_wr_en),
    .wr_addr(lnk.status_wr_port_addr),
    .wr_data(lnk.status_wr_value),
    .rd_addr(cal_port),
    .rd_data(ram_status)
  );

  // ==========================================
  // Quarter-rate status clock
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt <= '0;
      lnk.rx_status_quarter_clk <= 1'b0;
    end
    else if (rx_data_clk)
    begin
      div_cnt <= div_cnt + DIV_ONE;
      lnk.rx_status_quarter_clk <= (div_cnt + DIV_ONE) >= DIV_ONE + DIV_ONE;
    end
  end

  assign status_tick = rx_data_clk && div_cnt == DIV_LAST;

  // Own status tracks the shared FIFO fill for every port
  assign own_status = count == '0 ? ST_STARVING :
                      count < QUARTER ? ST_HUNGRY : ST_SATISFIED;

  // Calendar walks all ports, one per status clock
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cal_port <= '0;
      fifo_status <= ST_STARVING;
      fifo_status_port <= '0;
    end
    else if (status_tick)
    begin
      cal_port <= cal_port + PORT_ONE;
      fifo_status_port <= cal_port;
      fifo_status <= lnk.external_status_select ? ram_status : own_status;
    end
  end

  // ==========================================
  // Delay line on the receive clock path
  // invalid tap clamped
  assign tap_eff = lnk.clk_delay_tap > TAP_MAX ? TAP_MAX : lnk.clk_delay_tap;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dly_line <= '0;
      rx_clk_path <= 1'b0;
    end
    else
    begin
      dly_line <= {dly_line[TAP_MAX-1:0], rx_data_clk};
      rx_clk_path <= lnk.clk_delay_line_select ? dly_line[tap_eff] : rx_data_clk;
    end
  end
endmodule

// ===== include/srfp_pkg.sv
// Constants and types shared by both ends of the receive fabric port
// ==========================================
// Contract
// - Port address selects the status RAM entry
// - Status value belongs to presented port address
// - External select sends fabric status on interface
// - RAM written only under enable, write clock
// - Delay select held zero in dynamic alignment
// - Select zero bypasses delay, one inserts it
// - Tap sets delay, only 0 to 6
// - Status clock is data clock divided by four
// - Wide data with sixteen per-byte enables
// - Port identifier names current read word
// - Start flag high on first packet word
// - End flag high on last packet word
// - Empty flag: truly empty or quarter minus one
// - Error flag high on errored read word
package srfp_pkg;
  localparam int PORT_W = 8;
  localparam int STAT_W = 2;
  localparam int TAP_W = 3;
  localparam int DATA_W = 128;
  localparam int BE_W = 16;
  localparam int BUF_W = 3;
  localparam int DEPTH = 8;
  localparam int CNT_W = 4;
  localparam int DIV_W = 2;
  localparam int NPORT = 256;
  localparam logic [TAP_W-1:0] TAP_MAX = 3'h6;
  localparam logic [CNT_W-1:0] QUARTER = 4'h2;
  localparam logic [CNT_W-1:0] FIFO_FULL = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [BUF_W-1:0] PTR_ONE = 3'h1;
  localparam logic [DIV_W-1:0] DIV_ONE = 2'h1;
  localparam logic [DIV_W-1:0] DIV_LAST = 2'h3;
  localparam logic [PORT_W-1:0] PORT_ONE = 8'h01;
  // Status codes on the FIFO status interface
  localparam logic [STAT_W-1:0] ST_STARVING = 2'h0;
  localparam logic [STAT_W-1:0] ST_HUNGRY = 2'h1;
  localparam logic [STAT_W-1:0] ST_SATISFIED = 2'h2;
  // Avalon byte addresses of the controller registers
  localparam int AV_AW = 6;
  localparam logic [AV_AW-1:0] A_CTRL = 6'h00;
  localparam logic [AV_AW-1:0] A_STATWR = 6'h04;
  localparam logic [AV_AW-1:0] A_CMD = 6'h08;
  localparam logic [AV_AW-1:0] A_IRQ_STAT = 6'h0c;
  localparam logic [AV_AW-1:0] A_IRQ_MASK = 6'h10;
  localparam logic [AV_AW-1:0] A_META = 6'h14;
  localparam logic [AV_AW-1:0] A_DATA0 = 6'h18;
  localparam logic [AV_AW-1:0] A_DATA1 = 6'h1c;
  localparam logic [AV_AW-1:0] A_DATA2 = 6'h20;
  localparam logic [AV_AW-1:0] A_DATA3 = 6'h24;
  localparam logic [AV_AW-1:0] A_LINK = 6'h28;
  // CTRL fields
  localparam int C_EXT = 0;
  localparam int C_DSEL = 1;
  localparam int C_DYN = 2;
  localparam int C_ETYPE = 3;
  localparam int C_TAP = 4;
  localparam int C_BUF = 8;
  // IRQ bits: word read, start, end, error
  localparam int IRQ_W = 4;
  localparam int I_WORD = 0;
  localparam int I_SOP = 1;
  localparam int I_EOP = 2;
  localparam int I_ERR = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    SRFP_IDLE = 2'b00,
    SRFP_REQ = 2'b01,
    SRFP_WAIT = 2'b11
  } srfp_rd_state_t;
endpackage

// ===== include/srfp_if.sv
// Link between the receive core and the fabric logic
`timescale 1ns/1ns
interface srfp_if;
  import srfp_pkg::*;
  logic [PORT_W-1:0] status_wr_port_addr;
  logic [STAT_W-1:0] status_wr_value;
  logic external_status_select;
  logic status_ram_wr_en;
  logic status_ram_wr_clk;
  logic clk_delay_line_select;
  logic [TAP_W-1:0] clk_delay_tap;
  logic rx_status_quarter_clk;
  logic [BUF_W-1:0] wide_fifo_rd_addr;
  logic wide_fifo_rd;
  logic wide_fifo_rd_clk;
  logic wide_fifo_rd_valid;
  logic [DATA_W-1:0] wide_fifo_rd_data;
  logic [BE_W-1:0] wide_fifo_byte_en;
  logic [PORT_W-1:0] wide_fifo_port_ident;
  logic wide_fifo_pkt_start;
  logic wide_fifo_pkt_end;
  logic wide_fifo_empty_flag;
  logic wide_fifo_word_error;
  logic empty_flag_type_select;
  modport core (
    input status_wr_port_addr, status_wr_value, external_status_select,
    input status_ram_wr_en, status_ram_wr_clk, clk_delay_line_select, clk_delay_tap,
    input wide_fifo_rd_addr, wide_fifo_rd, wide_fifo_rd_clk, empty_flag_type_select,
    output rx_status_quarter_clk, wide_fifo_rd_valid, wide_fifo_rd_data,
    output wide_fifo_byte_en, wide_fifo_port_ident, wide_fifo_pkt_start,
    output wide_fifo_pkt_end, wide_fifo_empty_flag, wide_fifo_word_error
  );
  modport fabric (
    output status_wr_port_addr, status_wr_value, external_status_select,
    output status_ram_wr_en, status_ram_wr_clk, clk_delay_line_select, clk_delay_tap,
    output wide_fifo_rd_addr, wide_fifo_rd, wide_fifo_rd_clk, empty_flag_type_select,
    input rx_status_quarter_clk, wide_fifo_rd_valid, wide_fifo_rd_data,
    input wide_fifo_byte_en, wide_fifo_port_ident, wide_fifo_pkt_start,
    input wide_fifo_pkt_end, wide_fifo_empty_flag, wide_fifo_word_error
  );
endinterface

// ===== rtl/srfp_status_ram.sv
// Port status RAM, one two-bit entry per logical port
`timescale 1ns/1ns
module srfp_status_ram
  import srfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [srfp_pkg::PORT_W-1:0] wr_addr,
  input wire logic [srfp_pkg::STAT_W-1:0] wr_data,
  // Read side
  input wire logic [srfp_pkg::PORT_W-1:0] rd_addr,
  output logic [srfp_pkg::STAT_W-1:0] rd_data
);
  import srfp_pkg::*;
  logic [STAT_W-1:0] entry [NPORT];

  for (genvar i = 0; i < NPORT; i++)
  begin : g_entry
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        entry[i] <= ST_STARVING;
      else if (wr_en && wr_addr == PORT_W'(i))
        entry[i] <= wr_data;
    end
  end

  assign rd_data = entry[rd_addr];
endmodule

// ===== rtl/srfp_fabric.sv
// Fabric end: Avalon-MM controller driving status writes, delay control, FIFO reads
`timescale 1ns/1ns
module srfp_fabric
  import srfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [srfp_pkg::AV_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Link to core
  srfp_if.fabric lnk
);
  import srfp_pkg::*;
  logic [31:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] ev;
  logic [31:0] meta;
  logic [DATA_W-1:0] word;
  logic wr_take;
  logic pop_req;
  srfp_rd_state_t state;

  // One wait cycle per access; the write lands when waitrequest is low
  assign wr_take = avs_write && !avs_waitrequest;
  assign pop_req = wr_take && avs_address == A_CMD && avs_writedata[0];

  // ==========================================
  // Bus handshake and read mux
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        if (avs_address == A_CTRL)
          avs_readdata <= ctrl;
        else if (avs_address == A_IRQ_STAT)
          avs_readdata <= {28'h0, irq_stat};
        else if (avs_address == A_IRQ_MASK)
          avs_readdata <= {28'h0, irq_mask};
        else if (avs_address == A_META)
          avs_readdata <= meta;
        else if (avs_address == A_DATA0)
          avs_readdata <= word[31:0];
        else if (avs_address == A_DATA1)
          avs_readdata <= word[63:32];
        else if (avs_address == A_DATA2)
          avs_readdata <= word[95:64];
        else if (avs_address == A_DATA3)
          avs_readdata <= word[127:96];
        else if (avs_address == A_LINK)
          avs_readdata <= {29'h0, state == SRFP_IDLE, lnk.rx_status_quarter_clk,
                           lnk.wide_fifo_empty_flag};
        else
          avs_readdata <= '0;
      end
    end
  end

  // ==========================================
  // Control register and the static link pins it steers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= CTRL_RST;
      lnk.external_status_select <= 1'b0;
      lnk.clk_delay_line_select <= 1'b0;
      lnk.clk_delay_tap <= '0;
      lnk.empty_flag_type_select <= 1'b0;
      lnk.wide_fifo_rd_addr <= '0;
    end
    else
    begin
      if (wr_take && avs_address == A_CTRL)
        ctrl <= avs_writedata;
      lnk.external_status_select <= ctrl[C_EXT];
      lnk.empty_flag_type_select <= ctrl[C_ETYPE];
      lnk.wide_fifo_rd_addr <= ctrl[C_BUF +: BUF_W];
      lnk.clk_delay_line_select <= ctrl[C_DSEL] && !ctrl[C_DYN];
      if (state == SRFP_IDLE)
        lnk.clk_delay_tap <= ctrl[C_TAP +: TAP_W] > TAP_MAX ? TAP_MAX : ctrl[C_TAP +: TAP_W];
    end
  end

  // ==========================================
  // Status RAM write, one pulse per register write
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lnk.status_wr_port_addr <= '0;
      lnk.status_wr_value <= ST_STARVING;
      lnk.status_ram_wr_en <= 1'b0;
      lnk.status_ram_wr_clk <= 1'b0;
    end
    else
    begin
      lnk.status_ram_wr_en <= wr_take && avs_address == A_STATWR;
      lnk.status_ram_wr_clk <= wr_take && avs_address == A_STATWR;
      if (wr_take && avs_address == A_STATWR)
      begin
        lnk.status_wr_port_addr <= avs_writedata[PORT_W-1:0];
        lnk.status_wr_value <= avs_writedata[8 +: STAT_W];
      end
    end
  end

  // ==========================================
  // FIFO read sequence
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= SRFP_IDLE;
      lnk.wide_fifo_rd <= 1'b0;
      lnk.wide_fifo_rd_clk <= 1'b0;
    end
    else
    begin
      lnk.wide_fifo_rd <= 1'b0;
      lnk.wide_fifo_rd_clk <= 1'b0;
      case (state)
        SRFP_IDLE:
          if (pop_req && !lnk.wide_fifo_empty_flag)
            state <= SRFP_REQ;
        SRFP_REQ:
        begin
          lnk.wide_fifo_rd <= 1'b1;
          lnk.wide_fifo_rd_clk <= 1'b1;
          state <= SRFP_WAIT;
        end
        SRFP_WAIT:
          state <= SRFP_IDLE;
        default:
          state <= SRFP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      word <= '0;
      meta <= '0;
    end
    else if (lnk.wide_fifo_rd_valid)
    begin
      word <= lnk.wide_fifo_rd_data;
      meta <= {lnk.wide_fifo_word_error, lnk.wide_fifo_pkt_end, lnk.wide_fifo_pkt_start,
               5'h00, lnk.wide_fifo_port_ident, lnk.wide_fifo_byte_en};
    end
  end

  // ==========================================
  // Interrupts: set wins over write-one-to-clear
  assign ev = {IRQ_W{lnk.wide_fifo_rd_valid}} &
              {lnk.wide_fifo_word_error, lnk.wide_fifo_pkt_end, lnk.wide_fifo_pkt_start, 1'b1};

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_take && avs_address == A_IRQ_STAT)
        irq_stat <= (irq_stat & ~avs_writedata[IRQ_W-1:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
      if (wr_take && avs_address == A_IRQ_MASK)
        irq_mask <= avs_writedata[IRQ_W-1:0];
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule

// ===== bench/srfp_monitor.sv
// Concurrent checks on the link between the core and fabric ends
`timescale 1ns/1ns
module srfp_monitor
  import srfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Status write side
  input wire logic [srfp_pkg::PORT_W-1:0] status_wr_port_addr,
  input wire logic [srfp_pkg::STAT_W-1:0] status_wr_value,
  input wire logic status_ram_wr_en,
  input wire logic status_ram_wr_clk,
  input wire logic [srfp_pkg::TAP_W-1:0] clk_delay_tap,
  // Read side
  input wire logic wide_fifo_rd,
  input wire logic wide_fifo_rd_clk,
  input wire logic wide_fifo_rd_valid,
  input wire logic [srfp_pkg::DATA_W-1:0] wide_fifo_rd_data,
  input wire logic [srfp_pkg::BE_W-1:0] wide_fifo_byte_en,
  input wire logic wide_fifo_pkt_start,
  input wire logic wide_fifo_pkt_end,
  input wire logic wide_fifo_word_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Status write link
  chk_wr_clk_pair: assert property (
    status_ram_wr_en |-> status_ram_wr_clk) else $error("write enable without write clock");
  chk_wr_one_pulse: assert property (
    status_ram_wr_en |=> !status_ram_wr_en) else $error("write enable longer than one cycle");
  // Address and value may only move together with a write
  chk_addr_with_en: assert property (
    !$stable(status_wr_port_addr) || !$stable(status_wr_value) |-> status_ram_wr_en)
    else $error("status address or value moved without a write");
  chk_tap_in_range: assert property (
    clk_delay_tap <= TAP_MAX) else $error("delay tap above six");
  // ==========================================
  // Read link
  chk_valid_has_cause: assert property (
    wide_fifo_rd_valid |-> $past(wide_fifo_rd) && $past(wide_fifo_rd_clk))
    else $error("read valid without a read one cycle before");
  chk_fields_hold: assert property (
    !wide_fifo_rd_valid |-> $stable(wide_fifo_rd_data) && $stable(wide_fifo_byte_en))
    else $error("read data moved without a read");
  chk_start_on_word: assert property (
    $changed(wide_fifo_pkt_start) |-> wide_fifo_rd_valid) else $error("start flag moved alone");
  chk_end_on_word: assert property (
    $changed(wide_fifo_pkt_end) |-> wide_fifo_rd_valid) else $error("end flag moved alone");
  chk_err_on_word: assert property (
    $changed(wide_fifo_word_error) |-> wide_fifo_rd_valid) else $error("error flag moved alone");
  cov_start: cover property (wide_fifo_rd_valid && wide_fifo_pkt_start);
  cov_end: cover property (wide_fifo_rd_valid && wide_fifo_pkt_end);
  cov_err: cover property (wide_fifo_rd_valid && wide_fifo_word_error);
  cov_wr: cover property (status_ram_wr_en);
endmodule

// ===== bench/tb_top.sv
// Self-checking bench joining core and fabric ends
`timescale 1ns/1ns
module tb_top;
  import srfp_pkg::*;
  logic clock = 0, arst_n = 0, rx_data_clk = 0, in_valid = 0, in_ready;
  logic [127:0] in_data = '0;
  logic [15:0] in_be = '0;
  logic [7:0] in_port = '0, fifo_status_port;
  logic in_sop = 0, in_eop = 0, in_err = 0, rx_clk_path, avs_waitrequest, irq;
  logic [1:0] fifo_status;
  logic [5:0] avs_address = '0;
  logic avs_read = 0, avs_write = 0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd, st, em;
  logic [127:0] ed;
  logic [1:0] ram_m [256];
  logic [127:0] q_data [$];
  logic [31:0] q_meta [$];
  logic [2:0] bsel;
  int fails = 0, total_checks = 0, rx_gap = 3, rx_cnt = 0, n, np, nr;
  logic prev, ety;
  srfp_if lnk();
  srfp_core u_srfp_core (.clock(clock), .arst_n(arst_n), .lnk(lnk), .rx_data_clk(rx_data_clk),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_be(in_be),
    .in_port(in_port), .in_sop(in_sop), .in_eop(in_eop), .in_err(in_err),
    .fifo_status(fifo_status), .fifo_status_port(fifo_status_port), .rx_clk_path(rx_clk_path));
  srfp_fabric u_srfp_fabric (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .lnk(lnk));
  srfp_monitor u_srfp_monitor (.clock(clock), .arst_n(arst_n),
    .status_wr_port_addr(lnk.status_wr_port_addr), .status_wr_value(lnk.status_wr_value),
    .status_ram_wr_en(lnk.status_ram_wr_en), .status_ram_wr_clk(lnk.status_ram_wr_clk),
    .clk_delay_tap(lnk.clk_delay_tap), .wide_fifo_rd(lnk.wide_fifo_rd),
    .wide_fifo_rd_clk(lnk.wide_fifo_rd_clk), .wide_fifo_rd_valid(lnk.wide_fifo_rd_valid),
    .wide_fifo_rd_data(lnk.wide_fifo_rd_data), .wide_fifo_byte_en(lnk.wide_fifo_byte_en),
    .wide_fifo_pkt_start(lnk.wide_fifo_pkt_start), .wide_fifo_pkt_end(lnk.wide_fifo_pkt_end),
    .wide_fifo_word_error(lnk.wide_fifo_word_error));
  // ==========================================
  // Clock and data clock pulses
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    rx_cnt <= (rx_cnt >= rx_gap - 1) ? 0 : rx_cnt + 1;
    rx_data_clk <= (rx_cnt >= rx_gap - 1);
  end
  // ==========================================
  // Shared tasks
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task timed_out(input string what);
    fails++;
    $display("mismatch at %0t: timeout in %s", $time, what);
    close_out;
  endtask
  // Holds the request until waitrequest is sampled low
  task av(input logic r, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    avs_address <= a;
    avs_read <= r;
    avs_write <= !r;
    avs_writedata <= d;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0)
      timed_out("bus");
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic wait_sig(ref logic s, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clock);
      cnt++;
    end
    while (s !== 1'b1 && cnt < lim);
    if (s !== 1'b1)
      timed_out("wait");
  endtask
  task push(input logic s, input logic e);
    int k;
    @(posedge clock);
    in_valid <= 1;
    in_data <= {$urandom, $urandom, $urandom, $urandom};
    in_be <= 16'($urandom);
    in_port <= {5'($urandom), bsel};
    in_sop <= s;
    in_eop <= e;
    in_err <= 1'($urandom);
    wait_sig(in_ready, 20, k);
    q_data.push_back(in_data);
    q_meta.push_back({in_err, in_eop, in_sop, 5'h00, in_port, in_be});
    in_valid <= 0;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h2b8c));
    repeat (12) @(posedge clock);
    arst_n <= 1;
    rx_gap = 12;
    for (int t = 0; t < 10; t++)
    begin
      // Dynamic mode must force the bypass path
      av(0, A_CTRL, (t == 8) ? 32'h0 : (t == 9) ? 32'h6 : 32'h2 | (t << C_TAP));
      // Select and tap reach the link a cycle after the write lands
      repeat (2) @(posedge clock);
      wait_sig(rx_data_clk, 30, n);
      wait_sig(rx_clk_path, 20, n);
      chk(n, (t > 7) ? 1 : (t == 7) ? 8 : t + 2, "clock path delay");
    end
    $display("test delay line done");
    rx_gap = 3;
    prev = 0;
    np = 0;
    nr = 0;
    repeat (100)
    begin
      @(posedge clock);
      if (lnk.rx_status_quarter_clk === 1'b1 && prev !== 1'b1)
      begin
        if (nr > 0)
          chk(np, 4, "pulses per status clock");
        nr++;
        np = 0;
      end
      prev = lnk.rx_status_quarter_clk;
      if (rx_data_clk)
        np++;
    end
    chk(nr >= 3, 1, "status clock running");
    $display("test status clock done");
    for (int p = 0; p < 256; p++)
    begin
      ram_m[p] = 2'($urandom);
      av(0, A_STATWR, {22'h0, ram_m[p], 8'(p)});
    end
    av(0, A_CTRL, 32'h1);
    repeat (40) @(posedge clock);
    repeat (300)
    begin
      @(posedge clock);
      chk(fifo_status, ram_m[fifo_status_port], "external status");
    end
    av(0, A_CTRL, 32'h0);
    repeat (40) @(posedge clock);
    chk(fifo_status, ST_STARVING, "internal status empty");
    $display("test status ram done");
    bsel = 3'($urandom);
    for (int i = 0; i < 8; i++)
      push(i == 0, i == 7);
    repeat (40) @(posedge clock);
    chk(in_ready, 1'b0, "full refuses");
    chk(fifo_status, ST_SATISFIED, "internal status full");
    // A head for another buffer must not be popped
    av(0, A_CTRL, 32'(bsel ^ 3'h1) << C_BUF);
    av(0, A_CMD, 32'h1);
    repeat (10) @(posedge clock);
    av(1, A_IRQ_STAT, 32'h0);
    chk(rd[3:0], 4'h0, "mismatched read refused");
    for (int i = 0; i < 8; i++)
    begin
      // Quarter type on the last pop would refuse it, a count of one reads empty
      ety = ((i % 2) == 1) ^ (i > 5);
      av(0, A_CTRL, (32'(bsel) << C_BUF) | (32'(ety) << C_ETYPE));
      av(0, A_IRQ_MASK, (i == 3) ? 32'h0 : 32'hf);
      av(0, A_CMD, 32'h1);
      n = 0;
      do
      begin
        av(1, A_IRQ_STAT, 32'h0);
        n++;
      end
      while (rd[I_WORD] !== 1'b1 && n < 20);
      if (rd[I_WORD] !== 1'b1)
        timed_out("pop");
      st = rd;
      ed = q_data.pop_front();
      em = q_meta.pop_front();
      chk(lnk.wide_fifo_rd_data, ed, "link data");
      chk(lnk.wide_fifo_byte_en, em[15:0], "link byte enables");
      chk(lnk.wide_fifo_port_ident, em[23:16], "link port");
      chk(st[3:1], em[31:29], "error end start events");
      av(1, A_META, 32'h0);
      chk(rd & 32'he0ff_ffff, em, "meta word");
      for (int k = 0; k < 4; k++)
      begin
        av(1, A_DATA0 + 6'(4 * k), 32'h0);
        chk(rd, ed[32 * k +: 32], "data word");
      end
      chk(lnk.wide_fifo_empty_flag, ety ? q_data.size() <= 1 : q_data.size() == 0,
        "empty flag");
      if (i == 6)
        chk(fifo_status, ST_HUNGRY, "internal status hungry");
      chk(irq, i != 3, "irq level");
      av(0, A_IRQ_STAT, 32'hf);
      repeat (2) @(posedge clock);
      chk(irq, 1'b0, "irq cleared");
    end
    av(1, 6'h3c, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    av(1, A_LINK, 32'h0);
    chk(rd & 32'h5, 32'h5, "link idle and empty");
    av(1, A_CTRL, 32'h0);
    chk(rd, 32'(bsel) << C_BUF, "control readback");
    $display("test fifo reads done");
    close_out;
  end
endmodule
